// File: qdl_serial_load.sv
// Purpose: serial word capture and channel latch control of a quad converter
// Assumes: all pins asynchronous to clock; shift_clock at most clock/4
// Notes: pins are oversampled; edges are found on synchronised copies

`timescale 1ns/1ps
`default_nettype none

module qdl_serial_load #(
  parameter int NUM_CHAN = qdl_pkg::NUM_CHAN
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic device_select_n,
  input wire logic frame_sync,
  input wire logic shift_clock,
  input wire logic serial_in,
  input wire logic load_outputs_n,
  input wire logic hw_powerdown_n,
  output qdl_pkg::qdl_chan_s [3:0] chan_out,
  output logic frame_active,
  output logic word_strobe
);

  initial begin
    if (NUM_CHAN != 4) $error("qdl_serial_load: two select bits serve exactly four channels");
  end

  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  qdl_pkg::qdl_pins_s pins_raw;
  qdl_pkg::qdl_pins_s pins;

  assign pins_raw.device_select_n = device_select_n;
  assign pins_raw.frame_sync = frame_sync;
  assign pins_raw.shift_clock = shift_clock;
  assign pins_raw.serial_in = serial_in;
  assign pins_raw.load_outputs_n = load_outputs_n;
  assign pins_raw.hw_powerdown_n = hw_powerdown_n;

  qdl_sync #(
    .WIDTH($bits(qdl_pkg::qdl_pins_s)),
    .RST_VAL(qdl_pkg::PINS_RST)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .d(pins_raw),
    .q(pins)
  );

  // ---------------------------------------------------------------
  // frame state
  // ---------------------------------------------------------------
  typedef struct packed {
    qdl_pkg::qdl_frame_e st;
    logic [15:0] shreg;
    logic [4:0] cnt;
    logic fs_q;
    logic sclk_q;
    logic wr;
    logic [15:0] word;
  } qdl_main_s;

  qdl_main_s s_ff;
  qdl_main_s nxt_s;

  logic desel;
  logic fs_fall;
  logic fs_rise;
  logic sclk_fall;
  logic sclk_rise;

  always_comb begin
    desel = pins.device_select_n;
    fs_fall = s_ff.fs_q & ~pins.frame_sync;
    fs_rise = ~s_ff.fs_q & pins.frame_sync;
    sclk_fall = s_ff.sclk_q & ~pins.shift_clock;
    sclk_rise = ~s_ff.sclk_q & pins.shift_clock;
  end

  always_comb begin
    nxt_s = s_ff;
    nxt_s.wr = 1'b0;
    nxt_s.fs_q = pins.frame_sync;
    nxt_s.sclk_q = pins.shift_clock;
    case (s_ff.st)
      qdl_pkg::QDL_IDLE: begin
        if (!desel && fs_fall) begin
          nxt_s.st = qdl_pkg::QDL_SHIFT;
          nxt_s.cnt = qdl_pkg::CNT_RST;
        end
      end
      qdl_pkg::QDL_SHIFT: begin
        if (desel) begin
          nxt_s.st = qdl_pkg::QDL_IDLE;
        end else if (fs_fall) begin
          nxt_s.cnt = qdl_pkg::CNT_RST;
        end else if (fs_rise) begin
          nxt_s.st = qdl_pkg::QDL_IDLE;
          if (s_ff.cnt != qdl_pkg::CNT_RST) begin
            nxt_s.wr = 1'b1;
            nxt_s.word = s_ff.shreg;
          end
        end else if (sclk_fall) begin
          nxt_s.shreg = {s_ff.shreg[14:0], pins.serial_in};
          nxt_s.cnt = s_ff.cnt + 5'h01;
          if (s_ff.cnt == qdl_pkg::LAST_BIT_IDX) begin
            nxt_s.st = qdl_pkg::QDL_PEND;
          end
        end
      end
      qdl_pkg::QDL_PEND: begin
        if (sclk_rise || fs_rise || fs_fall || desel) begin
          nxt_s.wr = 1'b1;
          nxt_s.word = s_ff.shreg;
          nxt_s.st = qdl_pkg::QDL_IDLE;
          if (fs_fall && !desel) begin
            nxt_s.st = qdl_pkg::QDL_SHIFT;
            nxt_s.cnt = qdl_pkg::CNT_RST;
          end
        end
      end
      default: begin
        nxt_s.st = qdl_pkg::QDL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_ff.st <= qdl_pkg::QDL_IDLE;
      s_ff.shreg <= qdl_pkg::WORD_RST;
      s_ff.cnt <= qdl_pkg::CNT_RST;
      s_ff.fs_q <= 1'b1;
      s_ff.sclk_q <= 1'b1;
      s_ff.wr <= 1'b0;
      s_ff.word <= qdl_pkg::WORD_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ---------------------------------------------------------------
  // channel latches
  // ---------------------------------------------------------------
  logic [1:0] sel;
  logic [3:0] wr_vec;

  assign sel = {s_ff.word[qdl_pkg::SEL_HI_POS], s_ff.word[qdl_pkg::SEL_LO_POS]};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_chan
      assign wr_vec[gi] = s_ff.wr && (sel == 2'(gi));
      qdl_chan u_chan (
        .clock(clock),
        .rst(rst),
        .wr_en(wr_vec[gi]),
        .word(s_ff.word),
        .load_n(pins.load_outputs_n),
        .hw_pd_n(pins.hw_powerdown_n),
        .chan(chan_out[gi])
      );
    end
  endgenerate

  assign frame_active = (s_ff.st != qdl_pkg::QDL_IDLE);
  assign word_strobe = s_ff.wr;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_idle_no_write;
    s_ff.st == qdl_pkg::QDL_IDLE |=> !s_ff.wr;
  endproperty
  a_idle_no_write: assert property (p_idle_no_write)
    else $error("write without a frame");

  property p_frame_start;
    (!desel && fs_fall) |=> (s_ff.st == qdl_pkg::QDL_SHIFT && s_ff.cnt == qdl_pkg::CNT_RST);
  endproperty
  a_frame_start: assert property (p_frame_start)
    else $error("frame did not start with cleared counter");

  property p_shift_msb_first;
    (s_ff.st == qdl_pkg::QDL_SHIFT && !desel && !fs_fall && !fs_rise && sclk_fall)
      |=> s_ff.shreg == {$past(s_ff.shreg[14:0]), $past(pins.serial_in)};
  endproperty
  a_shift_msb_first: assert property (p_shift_msb_first)
    else $error("bit not shifted in msb first");

  property p_sixteenth_bit;
    (s_ff.st == qdl_pkg::QDL_SHIFT && s_ff.cnt == qdl_pkg::LAST_BIT_IDX && !desel
      && !fs_fall && !fs_rise && sclk_fall) |=> s_ff.st == qdl_pkg::QDL_PEND;
  endproperty
  a_sixteenth_bit: assert property (p_sixteenth_bit)
    else $error("sixteenth bit did not complete the word");

  sequence s_pend_rise;
    s_ff.st == qdl_pkg::QDL_PEND && sclk_rise;
  endsequence

  property p_update_on_rise;
    s_pend_rise |=> (s_ff.wr && s_ff.word == $past(s_ff.shreg)) ##1 !s_ff.wr;
  endproperty
  a_update_on_rise: assert property (p_update_on_rise)
    else $error("full word not transferred on shift clock rise");

  property p_early_end;
    (s_ff.st == qdl_pkg::QDL_SHIFT && !desel && !fs_fall && fs_rise && s_ff.cnt != qdl_pkg::CNT_RST)
      |=> s_ff.wr && s_ff.st == qdl_pkg::QDL_IDLE;
  endproperty
  a_early_end: assert property (p_early_end)
    else $error("early frame end did not transfer");

  property p_deselect_abort;
    (s_ff.st == qdl_pkg::QDL_SHIFT && desel) |=> (s_ff.st == qdl_pkg::QDL_IDLE && !s_ff.wr);
  endproperty
  a_deselect_abort: assert property (p_deselect_abort)
    else $error("deselected device kept its frame");

  property p_one_target;
    s_ff.wr |-> wr_vec == (4'h1 << sel);
  endproperty
  a_one_target: assert property (p_one_target)
    else $error("write did not hit exactly the selected channel");

  property p_reset_idle;
    @(posedge clock) disable iff (1'b0) rst |=> (s_ff.st == qdl_pkg::QDL_IDLE && !s_ff.wr);
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("frame logic not idle after reset");

  property p_deselect_no_start;
    (s_ff.st == qdl_pkg::QDL_IDLE && desel) |=> s_ff.st == qdl_pkg::QDL_IDLE;
  endproperty
  a_deselect_no_start: assert property (p_deselect_no_start)
    else $error("deselected device opened a frame");

  // one plain shift step: selected, no frame edge, shift clock fell
  sequence s_shift_step;
    s_ff.st == qdl_pkg::QDL_SHIFT && !desel && !fs_fall && !fs_rise && sclk_fall;
  endsequence

  property p_count_step;
    s_shift_step |=> s_ff.cnt == $past(s_ff.cnt) + 5'h01;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("bit counter did not advance on shift");

  property p_pend_wait;
    (s_ff.st == qdl_pkg::QDL_PEND && !desel && !fs_fall && !fs_rise && !sclk_rise)
      |=> (s_ff.st == qdl_pkg::QDL_PEND && !s_ff.wr);
  endproperty
  a_pend_wait: assert property (p_pend_wait)
    else $error("full word moved before the shift clock rise");

  property p_pend_deselect;
    (s_ff.st == qdl_pkg::QDL_PEND && desel) |=> (s_ff.wr && s_ff.st == qdl_pkg::QDL_IDLE);
  endproperty
  a_pend_deselect: assert property (p_pend_deselect)
    else $error("finished word lost on deselect");

  property p_pend_restart;
    (s_ff.st == qdl_pkg::QDL_PEND && !desel && fs_fall)
      |=> (s_ff.wr && s_ff.st == qdl_pkg::QDL_SHIFT && s_ff.cnt == qdl_pkg::CNT_RST);
  endproperty
  a_pend_restart: assert property (p_pend_restart)
    else $error("new frame did not follow a finished word");

  property p_empty_frame;
    (s_ff.st == qdl_pkg::QDL_SHIFT && !desel && !fs_fall && fs_rise && s_ff.cnt == qdl_pkg::CNT_RST)
      |=> (!s_ff.wr && s_ff.st == qdl_pkg::QDL_IDLE);
  endproperty
  a_empty_frame: assert property (p_empty_frame)
    else $error("frame without bits wrote a channel");

  property p_strobe_single;
    s_ff.wr |=> !s_ff.wr;
  endproperty
  a_strobe_single: assert property (p_strobe_single)
    else $error("word strobe longer than one cycle");

endmodule // qdl_serial_load

`default_nettype wire

// File: qdl_pkg.sv
// Purpose: shared constants and types of the quad converter serial load block
// Assumes: one 20 MHz system clock, synchronous active-high reset
// Notes: word layout is four control bits over a 12-bit code

package qdl_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;

  // ---------------------------------------------------------------
  // word layout
  // ---------------------------------------------------------------
  localparam int WORD_BITS = 16;
  localparam int CODE_BITS = 12;
  localparam int NUM_CHAN = 4;
  localparam int SEL_HI_POS = 15;
  localparam int SEL_LO_POS = 14;
  localparam int PWR_POS = 13;
  localparam int SPD_POS = 12;
  localparam int CODE_MSB = 11;
  localparam logic [4:0] LAST_BIT_IDX = 5'h0f;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [11:0] CODE_RST = 12'h000;
  localparam logic [4:0] CNT_RST = 5'h00;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    QDL_IDLE,
    QDL_SHIFT,
    QDL_PEND
  } qdl_frame_e;

  typedef struct packed {
    logic [11:0] code;
    logic power_down;
    logic fast;
  } qdl_chan_s;

  typedef struct packed {
    logic device_select_n;
    logic frame_sync;
    logic shift_clock;
    logic serial_in;
    logic load_outputs_n;
    logic hw_powerdown_n;
  } qdl_pins_s;

  // idle pin levels loaded into the synchroniser at reset
  localparam qdl_pins_s PINS_RST = 6'h3b;

endpackage : qdl_pkg

// File: qdl_sync.sv
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: inputs are asynchronous levels
// Notes: the first stage is read only by the second; reset loads idle levels

`timescale 1ns/1ps
`default_nettype none

module qdl_sync #(
  parameter int WIDTH = 6,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  initial begin
    if (WIDTH < 1) $error("qdl_sync: WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stab;
  } qdl_sync_s;

  qdl_sync_s s_ff;
  qdl_sync_s nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.meta = d;
    nxt_s.stab = s_ff.meta;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_ff <= '{meta: RST_VAL, stab: RST_VAL};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign q = s_ff.stab;

endmodule // qdl_sync

`default_nettype wire

// File: qdl_chan.sv
// Purpose: one channel: input latch, output latch and power/speed flags
// Assumes: load_outputs_n and power-down inputs already synchronised
// Notes: output latch follows the input latch while load is low

`timescale 1ns/1ps
`default_nettype none

module qdl_chan (
  input wire logic clock,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [15:0] word,
  input wire logic load_n,
  input wire logic hw_pd_n,
  output qdl_pkg::qdl_chan_s chan
);

  typedef struct packed {
    qdl_pkg::qdl_chan_s pend;
    qdl_pkg::qdl_chan_s act;
    logic pd_eff;
  } qdl_chst_s;

  qdl_chst_s s_ff;
  qdl_chst_s nxt_s;

  always_comb begin
    nxt_s = s_ff;
    if (wr_en) begin
      nxt_s.pend.code = word[qdl_pkg::CODE_MSB:0];
      nxt_s.pend.power_down = word[qdl_pkg::PWR_POS];
      nxt_s.pend.fast = word[qdl_pkg::SPD_POS];
    end
    if (!load_n) begin
      nxt_s.act = s_ff.pend;
    end
    nxt_s.pd_eff = nxt_s.act.power_down | ~hw_pd_n;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  always_comb begin
    chan.code = s_ff.act.code;
    chan.fast = s_ff.act.fast;
    chan.power_down = s_ff.pd_eff;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_hold_when_load_high;
    load_n |=> $stable(s_ff.act);
  endproperty
  a_hold_when_load_high: assert property (p_hold_when_load_high)
    else $error("output latch changed while load was high");

  property p_follow_when_load_low;
    !load_n |=> s_ff.act == $past(s_ff.pend);
  endproperty
  a_follow_when_load_low: assert property (p_follow_when_load_low)
    else $error("output latch did not take input latch");

  property p_hw_powerdown;
    !hw_pd_n |=> chan.power_down;
  endproperty
  a_hw_powerdown: assert property (p_hw_powerdown)
    else $error("hardware power-down not applied");

  property p_reset_clear;
    @(posedge clock) disable iff (1'b0) rst |=> (chan.code == qdl_pkg::CODE_RST && !chan.fast);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("latches not cleared by reset");

endmodule // qdl_chan

`default_nettype wire

// File: qdl_host.sv
// Purpose: host serial port model driving the serial pins of the load block
// Assumes: pins change just after rising clock edges
// Notes: shift clock stands high outside frames; data line inverted when released

`timescale 1ns/1ps
`default_nettype none

module qdl_host (
  input wire logic clock,
  output logic device_select_n,
  output logic frame_sync,
  output logic shift_clock,
  output logic serial_in
);
  initial begin
    device_select_n = 1'b1;
    frame_sync = 1'b1;
    shift_clock = 1'b1;
    serial_in = 1'b0;
  end

  // ---------------------------------------------------------------
  // one frame: sel high drives select low for it and keeps it low afterwards; sel low sends it deselected
  // ---------------------------------------------------------------
  task automatic send(input logic [15:0] w, input logic [4:0] nbits, input logic sel);
    int i;
    @(posedge clock);
    device_select_n <= ~sel;
    repeat (2) @(posedge clock);
    frame_sync <= 1'b0;
    repeat (3) @(posedge clock);
    for (i = 0; i < nbits; i++) begin
      serial_in <= w[15 - i];
      repeat (3) @(posedge clock);
      shift_clock <= 1'b0;
      repeat (3) @(posedge clock);
      shift_clock <= 1'b1;
    end
    repeat (3) @(posedge clock);
    serial_in <= ~serial_in;
    frame_sync <= 1'b1;
    repeat (3) @(posedge clock);
  endtask
endmodule // qdl_host

`default_nettype wire

// File: tb_qdl_serial_load.sv
// Purpose: self-checking bench of the quad converter serial load block
// Assumes: 20 MHz clock, host model on the serial pins
// Notes: expected channel values kept in a local table

`timescale 1ns/1ps
`default_nettype none

module tb_qdl_serial_load;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic load_outputs_n = 1'b0;
  logic hw_powerdown_n = 1'b1;
  logic device_select_n;
  logic frame_sync;
  logic shift_clock;
  logic serial_in;
  qdl_pkg::qdl_chan_s [3:0] chan_out;
  logic frame_active;
  logic word_strobe;
  int mismatches = 0;
  int total_checks = 0;
  int strobes = 0;
  logic [13:0] exp_ch [4];
  logic [15:0] words [4] = '{16'h1123, 16'h6456, 16'hb789, 16'hcabc};

  always #25 clock = ~clock;

  always @(negedge clock) begin
    if (word_strobe === 1'b1) begin
      strobes <= strobes + 1;
    end
  end

  qdl_host qdl_host_i (
    .clock(clock),
    .device_select_n(device_select_n),
    .frame_sync(frame_sync),
    .shift_clock(shift_clock),
    .serial_in(serial_in)
  );

  qdl_serial_load qdl_serial_load_i (
    .clock(clock),
    .rst(rst),
    .device_select_n(device_select_n),
    .frame_sync(frame_sync),
    .shift_clock(shift_clock),
    .serial_in(serial_in),
    .load_outputs_n(load_outputs_n),
    .hw_powerdown_n(hw_powerdown_n),
    .chan_out(chan_out),
    .frame_active(frame_active),
    .word_strobe(word_strobe)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [13:0] exp_of(input logic [15:0] w);
    return {w[11:0], w[13], w[12]};
  endfunction

  task automatic chk(input string name, input logic [13:0] exp, input logic [13:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask

  task automatic wr(input logic [15:0] w, input logic sel);
    qdl_host_i.send(w, 5'h10, sel);
    repeat (10) @(posedge clock);
  endtask

  task automatic chk_all(input logic [1:0] pd_or);
    int c;
    @(negedge clock);
    for (c = 0; c < 4; c++) begin
      chk("chan_out", exp_ch[c] | {12'h000, pd_or}, chan_out[c]);
    end
    @(posedge clock);
  endtask

  task automatic results;
    if (mismatches == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    int c;
    for (c = 0; c < 4; c++) begin
      exp_ch[c] = 14'h0000;
    end
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk_all(2'b00);
    @(negedge clock);
    chk("frame_active", 14'h0000, {13'h0000, frame_active});
    for (c = 0; c < 4; c++) begin
      wr(words[c], 1'b1);
      exp_ch[words[c][15:14]] = exp_of(words[c]);
    end
    chk_all(2'b00);
    load_outputs_n <= 1'b1;
    wr(16'h1fff, 1'b1);
    chk_all(2'b00);
    load_outputs_n <= 1'b0;
    repeat (6) @(posedge clock);
    exp_ch[0] = exp_of(16'h1fff);
    chk_all(2'b00);
    wr(16'h2555, 1'b0);
    chk_all(2'b00);
    hw_powerdown_n <= 1'b0;
    repeat (6) @(posedge clock);
    chk_all(2'b10);
    hw_powerdown_n <= 1'b1;
    repeat (6) @(posedge clock);
    chk_all(2'b00);
    @(negedge clock);
    chk("strobes", 14'h0005, 14'(strobes));
    qdl_host_i.send(16'hffff, 5'h04, 1'b1);
    repeat (10) @(posedge clock);
    @(negedge clock);
    chk("strobes", 14'h0006, 14'(strobes));
    chk("frame_active", 14'h0000, {13'h0000, frame_active});
    exp_ch[3] = exp_of(16'hffff);
    chk_all(2'b00);
    qdl_host_i.send(16'h0000, 5'h00, 1'b1);
    repeat (10) @(posedge clock);
    @(negedge clock);
    chk("strobes", 14'h0006, 14'(strobes));
    results();
  end

  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    results();
  end
endmodule // tb_qdl_serial_load

`default_nettype wire
